// [rtl/ecc_csr_error_logging.v]
`include "ecc_csr_map.vh"
`default_nettype none
module ecc_csr_error_logging (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   input wire bus_init,
   // Register access
   input wire reg_read,
   input wire reg_write,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   // Memory cycle from the bus side
   input wire word_read_cycle,
   input wire read_pause_cycle,
   input wire word_write_cycle,
   input wire byte_write_cycle,
   input wire [21:0] extended_bus_address,
   // Results from ecc_logic for this cycle
   input wire single_err,
   input wire double_err,
   input wire [5:0] syndrome,
   input wire [5:0] array_check,
   // Controls to ecc_logic and bus
   output reg correct_en,
   output reg use_reg_check,
   output reg [5:0] reg_check,
   output reg bus_parity_line,
   output reg error_led,
   output reg mode_diag,
   output reg mode_corr_dis
);
   // ****************************************
   // State
   // ****************************************
   reg [15:0] ctl;
   reg [6:0] addr_lo;
   reg [3:0] addr_hi;
   reg [6:0] chk_store;
   wire [15:0] rdata;
   wire prot;
   wire diag_eff;
   wire cdis_eff;
   wire rd_cyc;
   wire any_err;
   wire single_error_flag_flag;
   wire double_error_flag_flag;
   wire single_error_flag;
   wire double_error_flag;
   wire log_addr;
   wire log_syn;
   wire log_chk;

   assign diag_eff = ctl[`BIT_DIAG] & ~ctl[`BIT_RETRIEVE];
   assign rd_cyc = word_read_cycle | read_pause_cycle;
   assign any_err = single_err | double_err;

   ecc_region_check u_region (
      .inh_en(ctl[`BIT_INH_EN]),
      .inh_ptr(ctl[`BIT_INH_PTR]),
      .diag_any(diag_eff | ctl[`BIT_CORR_DIS]),
      .addr(extended_bus_address),
      .prot(prot)
   );

   ecc_read_mux u_mux (
      .ctl(ctl),
      .addr_lo(addr_lo),
      .addr_hi(addr_hi),
      .chk_store(chk_store),
      .rdata(rdata)
   );

   // Protected accesses get normal-mode correction, check source and check capture; address and syndrome logging still stop in diag mode
   wire diag_u;
   wire cdis_u;
   assign diag_u = diag_eff & ~prot;
   assign cdis_u = ctl[`BIT_CORR_DIS] & ~prot;
   assign cdis_eff = cdis_u;

   // ****************************************
   // Error classification
   // ****************************************
   assign double_error_flag = rd_cyc & double_err;
   assign single_error_flag = rd_cyc & single_err & ~double_err;
   // Correction disabled prot-side keeps bit 4 off per disable/protected case
   assign single_error_flag_flag = single_error_flag & ~(ctl[`BIT_CORR_DIS] & prot & ~diag_eff);
   assign double_error_flag_flag = double_error_flag | (cdis_eff & rd_cyc & any_err);
   // Logging: address only outside diag; single error does not overwrite pending double unless correction is disabled
   assign log_addr = rd_cyc & any_err & ~diag_u & ~(diag_eff & prot)
      & (double_err | cdis_eff | ~ctl[`BIT_DOUBLE_ERROR_FLAG]);
   assign log_syn = (rd_cyc | byte_write_cycle) & any_err & ~ctl[`BIT_DIAG]
      & (double_err | cdis_eff | ~ctl[`BIT_DOUBLE_ERROR_FLAG]);
   assign log_chk = rd_cyc & diag_u;

   // ****************************************
   // Register update
   // ****************************************
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctl <= `CSR_RESET;
         addr_lo <= 7'h00;
         addr_hi <= 4'h0;
         chk_store <= 7'h00;
      end else if (bus_init) begin
         ctl <= `CSR_RESET;
         addr_lo <= 7'h00;
         addr_hi <= 4'h0;
         chk_store <= 7'h00;
      end else begin
         if (reg_write) begin
            ctl <= reg_wdata & 16'hE01F;
            // Address log stays; check storage takes written bits
            chk_store <= reg_wdata[`FLD_HI:`FLD_LO];
         end
         // Hardware set wins over a same-cycle register write
         if (single_error_flag_flag)
            ctl[`BIT_SINGLE_ERROR_FLAG] <= 1'b1;
         if (double_error_flag_flag)
            ctl[`BIT_DOUBLE_ERROR_FLAG] <= 1'b1;
         if (log_addr) begin
            addr_lo <= extended_bus_address[17:11];
            addr_hi <= extended_bus_address[21:18];
         end
         if (log_syn)
            chk_store <= {1'b0, syndrome};
         else if (log_chk)
            chk_store <= {1'b0, array_check};
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
         correct_en <= 1'b1;
         use_reg_check <= 1'b0;
         reg_check <= 6'h00;
         bus_parity_line <= 1'b0;
         error_led <= 1'b0;
         mode_diag <= 1'b0;
         mode_corr_dis <= 1'b0;
      end else begin
         reg_rdata <= reg_read ? rdata : 16'h0000;
         correct_en <= ~cdis_eff;
         // Diag write uses register checks; otherwise fresh checks from logic
         use_reg_check <= diag_u & (word_write_cycle | byte_write_cycle);
         reg_check <= chk_store[5:0];
         bus_parity_line <= ctl[`BIT_PARITY_EN] & double_error_flag_flag;
         error_led <= bus_init ? 1'b0 : (error_led | double_error_flag);
         mode_diag <= diag_eff;
         mode_corr_dis <= ctl[`BIT_CORR_DIS];
      end
   end
   // Single errors raise nothing toward the processor unless correction is disabled and parity is enabled, which drives bus_parity_line
endmodule // ecc_csr_error_logging
`default_nettype wire

// [rtl/ecc_csr_map.vh]
`ifndef ECC_CSR_MAP_VH
`define ECC_CSR_MAP_VH
// ****************************************
// Control and status register bit map
// ****************************************
`define CSR_WIDTH 16
`define CSR_RESET 16'h0000
`define BIT_PARITY_EN 0
`define BIT_CORR_DIS 1
`define BIT_DIAG 2
`define BIT_INH_PTR 3
`define BIT_SINGLE_ERROR_FLAG 4
`define FLD_LO 5
`define FLD_HI 11
`define BIT_UNUSED 12
`define BIT_INH_EN 13
`define BIT_RETRIEVE 14
`define BIT_DOUBLE_ERROR_FLAG 15
// Address bit that splits first and second 16K words (word address)
`define REGION_BIT 14
`define REGION_TOP_LO 15
`define REGION_TOP_HI 21
`define CHK_WIDTH 6
`endif

// [rtl/ecc_region_check.v]
`include "ecc_csr_map.vh"
`default_nettype none
// ****************************************
// Protected region decode
// ****************************************
module ecc_region_check (
   // Mode
   input wire inh_en,
   input wire inh_ptr,
   input wire diag_any,
   // Access
   input wire [21:0] addr,
   // Result
   output wire prot
);
   wire in_low32k;
   // Region is word address below 32K words, split at 16K
   assign in_low32k = (addr[`REGION_TOP_HI:`REGION_TOP_LO] == 7'h00);
   assign prot = inh_en & diag_any & in_low32k & (addr[`REGION_BIT] == inh_ptr);
endmodule // ecc_region_check
`default_nettype wire

// [rtl/ecc_read_mux.v]
`include "ecc_csr_map.vh"
`default_nettype none
// ****************************************
// Register read value assembly
// ****************************************
module ecc_read_mux (
   // Stored state
   input wire [15:0] ctl,
   input wire [6:0] addr_lo,
   input wire [3:0] addr_hi,
   input wire [6:0] chk_store,
   // Result
   output reg [15:0] rdata
);
   always @* begin
      rdata = ctl;
      rdata[`BIT_UNUSED] = 1'b0;
      // Retrieval bit overrides diag view, since it blocks diag mode
      if (ctl[`BIT_DIAG] & ~ctl[`BIT_RETRIEVE]) begin
         rdata[`FLD_HI:`FLD_LO] = chk_store;
      end else if (ctl[`BIT_RETRIEVE]) begin
         rdata[`FLD_HI:`FLD_LO] = {3'h0, addr_hi};
         if (ctl[`BIT_DIAG] & ctl[`BIT_INH_EN])
            rdata[`FLD_HI] = 1'b1;
      end else begin
         rdata[`FLD_HI:`FLD_LO] = addr_lo;
      end
   end
endmodule // ecc_read_mux
`default_nettype wire

// [dv/ecc_log_monitor.sv]
`default_nettype none
module ecc_log_monitor (
   input wire logic sys_clk, nrst, bus_init, reg_read, reg_write,
   input wire logic [15:0] reg_wdata, reg_rdata,
   input wire logic word_read_cycle, read_pause_cycle,
   input wire logic word_write_cycle, byte_write_cycle,
   input wire logic double_err, use_reg_check, bus_parity_line,
   input wire logic error_led, mode_diag, mode_corr_dis, correct_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_dbl; double_err && (word_read_cycle || read_pause_cycle); endsequence
   sequence s_ret; reg_write && reg_wdata[14] ##1 !reg_write; endsequence
   sequence s_init; bus_init ##1 !reg_write; endsequence
   property p_b12; reg_read |=> !reg_rdata[12]; endproperty
   a_b12: assert property (p_b12) else $error("bit 12 set");
   property p_mt; reg_rdata[2] && reg_rdata[13] && reg_rdata[14] |-> reg_rdata[11]; endproperty
   a_mt: assert property (p_mt) else $error("type bit low");
   property p_hi; reg_rdata[14] |-> reg_rdata[10:9] == 2'h0; endproperty
   a_hi: assert property (p_hi) else $error("high zeros");
   property p_led; s_dbl and !bus_init |=> error_led; endproperty
   a_led: assert property (p_led) else $error("led off");
   property p_ledh; error_led && !bus_init |=> error_led; endproperty
   a_ledh: assert property (p_ledh) else $error("led dropped");
   property p_par; bus_parity_line |-> $past(word_read_cycle || read_pause_cycle); endproperty
   a_par: assert property (p_par) else $error("stray parity");
   property p_init;
      s_init |=> !mode_diag && !mode_corr_dis && correct_en;
   endproperty
   a_init: assert property (p_init) else $error("init");
   property p_ret; s_ret |=> !mode_diag; endproperty
   a_ret: assert property (p_ret) else $error("diag on");
   property p_urc; use_reg_check |-> $past(word_write_cycle || byte_write_cycle); endproperty
   a_urc: assert property (p_urc) else $error("check use");
endmodule // ecc_log_monitor
bind ecc_csr_error_logging ecc_log_monitor u_mon (.*);
`default_nettype wire

// [dv/ecc_array_model.sv]
`default_nettype none
module ecc_array_model (
   input wire logic sys_clk,
   input wire logic rd,
   input wire logic [3:0] idx,
   input wire logic [1:0] fault,
   input wire logic wr_chk,
   input wire logic [5:0] reg_check,
   output logic single_err,
   output logic double_err,
   output logic [5:0] syndrome,
   output logic [5:0] array_check
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] chk [16];
   logic [5:0] junk = 6'h15;
   // Toggle outside reads so stale results never look valid
   always @(posedge sys_clk) begin
      junk <= ~junk;
      if (wr_chk) chk[idx] <= reg_check;
   end
   assign single_err = rd & fault[0];
   assign double_err = rd & fault[1];
   assign syndrome = rd ? {2'h2, idx} : junk;
   assign array_check = rd ? chk[idx] : junk;
endmodule // ecc_array_model
`default_nettype wire

// [dv/ecc_csr_error_logging_tb.sv]
`default_nettype none
module ecc_csr_error_logging_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, nrst = 0, bus_init = 0, reg_read = 0, reg_write = 0;
   logic word_read_cycle = 0, read_pause_cycle = 0, word_write_cycle = 0, byte_write_cycle = 0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [21:0] extended_bus_address = 22'h000000, a;
   logic [1:0] fault = 2'h0, o;
   logic single_err, double_err, correct_en, use_reg_check, bus_parity_line;
   logic error_led, mode_diag, mode_corr_dis;
   logic [5:0] syndrome, array_check, reg_check, c;
   logic [15:0] v;
   int errors = 0, samples_checked = 0, cyc = 0, i;
   ecc_csr_error_logging dut (.*);
   ecc_array_model mdl (.sys_clk, .rd(word_read_cycle | read_pause_cycle),
      .idx(extended_bus_address[3:0]), .fault, .wr_chk(use_reg_check), .reg_check,
      .single_err, .double_err, .syndrome, .array_check);
   initial forever #50 sys_clk = ~sys_clk;
   task close_out;
      if (errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge sys_clk) if (++cyc == 5000) begin
      errors++;
      close_out;
   end
   task chk(input string n, input logic [15:0] s, e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(input logic [15:0] d);
      @(posedge sys_clk);
      reg_write <= 1;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 0;
   endtask
   task rd(input logic [15:0] e);
      @(posedge sys_clk);
      reg_read <= 1;
      @(posedge sys_clk);
      reg_read <= 0;
      #1 chk("reg_rdata", reg_rdata, e);
   endtask
   // One memory cycle: 0 read, 1 write, 2 read pause, 3 byte write
   task mem(input int k, input logic [1:0] f);
      @(posedge sys_clk);
      {byte_write_cycle, read_pause_cycle, word_write_cycle, word_read_cycle} <= 4'h1 << k;
      extended_bus_address <= a;
      fault <= f;
      @(posedge sys_clk);
      {byte_write_cycle, read_pause_cycle, word_write_cycle, word_read_cycle} <= 4'h0;
      fault <= 2'h0;
      #1 o = {bus_parity_line, use_reg_check};
   endtask
   initial begin
      void'($urandom(30601));
      repeat (16) @(posedge sys_clk);
      nrst <= 1;
      for (i = 0; i < 8; i++) begin
         v = $urandom;
         wr((v & 16'hFFFB) | 16'h1000);
         rd(v & 16'hE01B);
      end
      @(posedge sys_clk);
      bus_init <= 1;
      @(posedge sys_clk);
      bus_init <= 0;
      rd(16'h0000);
      for (i = 1; i < 3; i++) begin
         a = $urandom;
         wr(16'h0000);
         mem(i * 2 - 2, i[1:0]);
         chk("parity", {14'h0, o}, 16'h0);
         chk("led", {15'h0, error_led}, {15'h0, i[1]});
         rd({i[1], 3'h0, a[17:11], i[0], 4'h0});
         wr(16'h4000);
         rd({3'h2, 4'h0, a[21:18], 5'h00});
         wr(16'h0000);
         rd({4'h0, a[17:11], 5'h00});
      end
      c = $urandom;
      a = $urandom;
      wr({4'h0, 1'b1, c, 5'h04});
      rd({4'h0, 1'b1, c, 5'h04});
      mem(1, 2'h0);
      chk("use_chk", {14'h0, o}, 16'h1);
      chk("reg_check", {10'h0, reg_check}, {10'h0, c});
      wr(16'h0004);
      rd(16'h0004);
      mem(0, 2'h0);
      rd({5'h00, c, 5'h04});
      for (i = 0; i < 2; i++) begin
         wr({3'h1, 9'h000, i[0], 3'h4});
         a = {7'h00, i[0], 14'h2A5};
         mem(3, 2'h0);
         chk("prot", {14'h0, o}, 16'h0);
         a[14] = ~i[0];
         mem(1, 2'h0);
         chk("unprot", {14'h0, o}, 16'h1);
      end
      wr(16'h0003);
      a = $urandom;
      mem(0, 2'h1);
      chk("parity", {14'h0, o}, 16'h2);
      chk("corr_dis", {15'h0, mode_corr_dis}, 16'h1);
      chk("correct_en", {15'h0, correct_en}, 16'h0);
      rd({1'b1, 3'h0, a[17:11], 1'b1, 4'h3});
      wr(16'h6004);
      rd({3'h3, 2'h1, 2'h0, a[21:18], 5'h04});
      close_out;
   end
endmodule // ecc_csr_error_logging_tb
`default_nettype wire
